// [bench/test_ubc_top.sv]
`timescale 1ns/10ps
module test_ubc_top;
  import ubc_pkg::*;
  logic           i_mclk = 1'b0;
  logic           i_nrst = 1'b0;
  logic           i_hsel = 1'b0;
  logic           i_hwrite = 1'b0;
  logic [1:0]     i_htrans = 2'b00;
  logic [2:0]     i_hsize = 3'h2;
  logic [31:0]    i_haddr = 32'h0;
  logic [31:0]    i_hwdata = 32'h0;
  logic [31:0]    o_hrdata, q;
  logic           o_hreadyout, o_hresp, o_usb_en, o_addr_en, o_pad_idle;
  logic           o_resume_k, o_vref_out, o_vref_oe, o_usb_irq;
  wire logic      i_hready = o_hreadyout;
  ubc_sie_type    i_sie;
  ubc_ep_ctl_type o_ep;
  int             error_cnt = 0;
  int             n_compared = 0;
  int             k;
  ubc_top #(.SUSP_CYC(20), .RMIN_CYC(30), .RDRV_CYC(10)) i_dut (.*);
  ubc_host i_host (.i_mclk(i_mclk), .o_sie(i_sie));
  // Clock and watchdog
  initial begin
    forever #4 i_mclk = ~i_mclk;
  end
  initial begin
    repeat (20000) @(posedge i_mclk);
    error_cnt++;
    results();
  end
  task automatic w(input int n);
    repeat (n) @(posedge i_mclk);
  endtask : w
  // One AHB-Lite single word transfer
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    i_hsel <= 1'b1;
    i_haddr <= {24'h0, a};
    i_htrans <= 2'b10;
    i_hwrite <= wr;
    do @(posedge i_mclk); while (o_hreadyout !== 1'b1);
    i_hsel <= 1'b0;
    i_htrans <= 2'b00;
    i_hwdata <= d;
    do @(posedge i_mclk); while (o_hreadyout !== 1'b1);
    q = o_hrdata;
  endtask : bus
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rdc
  task automatic results;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results
  // Main sequence
  initial begin
    w(6);
    i_nrst <= 1'b1;
    w(1);
    rdc(OFS_CTRL, 32'h0);
    bus(1'b1, OFS_CTRL, 32'h90);
    w(3);
    chk({31'h0, o_vref_oe}, 32'h0);
    bus(1'b1, OFS_CTRL, 32'h80);
    bus(1'b1, OFS_EVT_EN, 32'h7F39);
    w(3);
    chk({31'h0, o_vref_oe}, 32'h1);
    i_host.evt(0, 3'd0, 11'h5A5, 1'b1);
    rdc(OFS_EVT, 32'h08);
    rdc(OFS_FNUM, 32'hDA5);
    chk({31'h0, o_usb_irq}, 32'h1);
    i_host.evt(0, 3'd0, 11'h123, 1'b0);
    rdc(OFS_FNUM, 32'h1123);
    bus(1'b1, OFS_EVT, 32'h08);
    rdc(OFS_EVT, 32'h0);
    chk({31'h0, o_usb_irq}, 32'h0);
    bus(1'b1, OFS_EP_STA, 32'h20);
    w(3);
    chk({25'h0, o_ep.stall}, 32'h01);
    i_host.evt(4, 3'd0, 11'h0, 1'b0);
    rdc(OFS_EP_STA, 32'h28);
    chk({31'h0, o_usb_irq}, 32'h1);
    i_host.evt(1, 3'd0, 11'h0, 1'b0);
    rdc(OFS_EP_STA, 32'h84);
    bus(1'b1, OFS_EP_STA, 32'h0C);
    bus(1'b1, OFS_EP_SEL, 32'h2);
    bus(1'b1, OFS_EP_CFG, 32'h1);
    bus(1'b1, OFS_EP_STA, 32'h20);
    rdc(OFS_EP_STA, 32'h0);
    bus(1'b1, OFS_EP_SEL, 32'h1);
    bus(1'b1, OFS_EP_CFG, 32'h2);
    i_host.evt(2, 3'd1, 11'h0, 1'b0);
    rdc(OFS_EP_STA, 32'h82);
    i_host.evt(2, 3'd1, 11'h0, 1'b1);
    rdc(OFS_EP_STA, 32'h42);
    bus(1'b1, OFS_EP_RST, 32'h02);
    bus(1'b1, OFS_EP_RST, 32'h00);
    rdc(OFS_EP_STA, 32'h0);
    bus(1'b1, OFS_EP_STA, 32'h10);
    i_host.evt(3, 3'd1, 11'h0, 1'b0);
    rdc(OFS_EP_STA, 32'h01);
    bus(1'b1, OFS_EP_STA, 32'h01);
    i_host.lvl(1'b1, 1'b0);
    w(30);
    rdc(OFS_EVT, 32'h01);
    bus(1'b1, OFS_EVT, 32'h01);
    bus(1'b1, OFS_CTRL, 32'hC0);
    w(2);
    chk({31'h0, o_pad_idle}, 32'h1);
    i_host.lvl(1'b0, 1'b0);
    w(3);
    chk({31'h0, o_pad_idle}, 32'h0);
    rdc(OFS_EVT, 32'h20);
    bus(1'b1, OFS_CTRL, 32'h80);
    bus(1'b1, OFS_EVT, 32'h20);
    i_host.lvl(1'b1, 1'b0);
    w(25);
    bus(1'b1, OFS_EVT, 32'h01);
    bus(1'b1, OFS_CTRL, 32'hA4);
    w(1);
    rdc(OFS_CTRL, 32'hAC);
    k = 0;
    repeat (60) begin
      @(posedge i_mclk);
      k += o_resume_k;
    end
    chk(k, 32'd11);
    rdc(OFS_CTRL, 32'hA4);
    i_host.lvl(1'b0, 1'b0);
    bus(1'b1, OFS_CTRL, 32'h83);
    w(3);
    chk({31'h0, o_addr_en}, 32'h1);
    i_host.lvl(1'b0, 1'b1);
    w(340);
    chk({31'h0, o_addr_en}, 32'h0);
    i_host.lvl(1'b0, 1'b0);
    w(3);
    rdc(OFS_CTRL, 32'h80);
    rdc(OFS_EVT, 32'h10);
    rdc(OFS_EVT_EN, 32'h0);
    chk({31'h0, o_usb_irq}, 32'h0);
    results();
  end
endmodule : test_ubc_top

// [bench/ubc_host.sv]
`timescale 1ns/10ps
module ubc_host (
  input  wire logic            i_mclk,
  output ubc_pkg::ubc_sie_type o_sie
);
  import ubc_pkg::*;
  initial o_sie = '0;
  // One event pulse, then pulses drop and released qualifiers invert
  task automatic evt(input int k, input logic [2:0] ep, input logic [10:0] fn, input logic b);
    ubc_sie_type v;
    v = o_sie;
    v.ep = ep;
    v.frame_num = fn;
    v.sof_crc_ok = b;
    v.out_bank1 = b;
    v.data1 = b;
    {v.sof, v.setup, v.out_ok, v.in_ack, v.stall_sent} = 5'h10 >> k;
    o_sie <= v;
    @(posedge i_mclk);
    o_sie <= (~v & ~24'h800663) | (v & 24'h000003);
  endtask : evt
  // Line state levels
  task automatic lvl(input logic idle, input logic se0);
    o_sie.bus_idle <= idle;
    o_sie.se0 <= se0;
    @(posedge i_mclk);
  endtask : lvl
endmodule : ubc_host

// [bench/ubc_monitor.sv]
`timescale 1ns/10ps
module ubc_monitor (
  input  wire logic                   i_mclk,
  input  wire logic                   i_nrst,
  input  wire ubc_pkg::ubc_sie_type   i_sie,
  input  wire ubc_pkg::ubc_ep_ctl_type o_ep,
  input  wire logic                   o_hreadyout,
  input  wire logic                   o_hresp,
  input  wire logic                   o_usb_en,
  input  wire logic                   o_addr_en,
  input  wire logic                   o_resume_k,
  input  wire logic                   o_vref_out,
  input  wire logic                   o_usb_irq
);
  import ubc_pkg::*;
  logic [8:0] se0_cnt_r;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  // Length of the current SE0 run, saturating
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst)
      se0_cnt_r <= '0;
    else if (!i_sie.se0)
      se0_cnt_r <= '0;
    else if (se0_cnt_r != 9'h1FF)
      se0_cnt_r <= se0_cnt_r + 9'h001;
  end
  a_bus_okay: assert property (o_hreadyout && !o_hresp) else $error("bus not ready or okay");
  a_vref_high: assert property (o_vref_out) else $error("pull-up supply level low");
  a_reset_addr: assert property (se0_cnt_r > BUS_RST_CYC + 2 |-> !o_addr_en)
    else $error("address enable kept in bus reset");
  a_reset_keeps: assert property ($fell(i_sie.se0) && o_usb_en |=> o_usb_en)
    else $error("enable lost at end of reset");
  a_setup_ctrl: assert property (o_usb_en && i_sie.setup && i_sie.ep == 3'd0
    |=> o_ep.toggle[0] && !o_ep.stall[0]) else $error("setup on ep0 mishandled");
  a_resume_len: assert property ($rose(o_resume_k) |-> o_resume_k[*8])
    else $error("resume signalling too short");
  a_irq_off: assert property ((!o_usb_en)[*3] |-> !o_usb_irq)
    else $error("irq while disabled");
  a_ep_idle: assert property ((!o_usb_en)[*3] |-> o_ep == '0) else $error("ep live while off");
endmodule : ubc_monitor
bind ubc_top ubc_monitor i_mon (.*);

// [include/ubc_pkg.sv]
package ubc_pkg;
  // Clock and bus rates
  localparam int unsigned CLK_MHZ       = 125;
  localparam int unsigned FS_MBPS       = 12;
  // Bus idle longer than this marks a suspend
  localparam int unsigned SUSP_IDLE_MS  = 3;
  localparam int unsigned SUSP_IDLE_CYC = SUSP_IDLE_MS * 1000 * CLK_MHZ + 1;
  // Least time in suspend before an upstream resume
  localparam int unsigned RSM_MIN_MS    = 5;
  localparam int unsigned RSM_MIN_CYC   = RSM_MIN_MS * 1000 * CLK_MHZ;
  // Length of the driven resume signalling
  localparam int unsigned RSM_DRIVE_MS  = 2;
  localparam int unsigned RSM_DRIVE_CYC = RSM_DRIVE_MS * 1000 * CLK_MHZ;
  // Bus reset: SE0 for at least this many full-speed bit times
  localparam int unsigned BUS_RST_BITS  = 32;
  localparam int unsigned BUS_RST_CYC   = (BUS_RST_BITS * CLK_MHZ + FS_MBPS - 1) / FS_MBPS;
  localparam int unsigned NEP           = 7;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_EVT    = 8'h04;
  localparam logic [7:0] OFS_EVT_EN = 8'h08;
  localparam logic [7:0] OFS_EP_SEL = 8'h0C;
  localparam logic [7:0] OFS_EP_STA = 8'h10;
  localparam logic [7:0] OFS_EP_CFG = 8'h14;
  localparam logic [7:0] OFS_EP_RST = 8'h18;
  localparam logic [7:0] OFS_FNUM   = 8'h1C;

  // Global control bits
  localparam int unsigned CB_ADDRESS_ENABLE_BIT = 0;
  localparam int unsigned CB_CONFIGURED_BIT  = 1;
  localparam int unsigned CB_REMOTE_WAKEUP_ENABLE = 2;
  localparam int unsigned CB_UPSTREAM_RESUME_FLAG  = 3;
  localparam int unsigned CB_DETACH = 4;
  localparam int unsigned CB_SDWUP  = 5;
  localparam int unsigned CB_SUSPCK = 6;
  localparam int unsigned CB_USBE   = 7;
  localparam logic [7:0]  CTRL_RST  = 8'h00;

  // Global event bits
  localparam int unsigned EB_SUSP = 0;
  localparam int unsigned EB_SOF  = 3;
  localparam int unsigned EB_EOR  = 4;
  localparam int unsigned EB_WUP  = 5;
  localparam logic [7:0]  EVT_MASK = 8'h39;
  localparam int unsigned EN_EP_LSB = 8;

  // Endpoint status bits
  localparam int unsigned SB_TRANSMIT_COMPLETE_FLAG = 0;
  localparam int unsigned SB_RXB0   = 1;
  localparam int unsigned SB_SETUP  = 2;
  localparam int unsigned SB_STALLD = 3;
  localparam int unsigned SB_TRANSMIT_READY_FLAG  = 4;
  localparam int unsigned SB_STALLQ = 5;
  localparam int unsigned SB_RXB1   = 6;
  localparam int unsigned SB_TOGGLE = 7;
  localparam logic [7:0]  STA_FLAGS = 8'h4F;

  // Frame number register fields
  localparam int unsigned FB_FRAME_CRC_GOOD  = 11;
  localparam int unsigned FB_FRAME_CRC_ERROR = 12;

  // Endpoint types
  localparam logic [1:0] EPT_CTRL = 2'b00;
  localparam logic [1:0] EPT_ISO  = 2'b01;
  localparam logic [1:0] EPT_BULK = 2'b10;

  // Event pulses and line state from the packet engine
  typedef struct packed {
    logic        sof;
    logic        sof_crc_ok;
    logic [10:0] frame_num;
    logic        setup;
    logic        out_ok;
    logic        out_bank1;
    logic        data1;
    logic        in_ack;
    logic        stall_sent;
    logic [2:0]  ep;
    logic        bus_idle;
    logic        se0;
  } ubc_sie_type;

  // Per-endpoint controls toward the packet engine
  typedef struct packed {
    logic [NEP-1:0] stall;
    logic [NEP-1:0] tx_rdy;
    logic [NEP-1:0] toggle;
  } ubc_ep_ctl_type;
endpackage : ubc_pkg

// [logic/ubc_cnt.sv]
`timescale 1ns/10ps
module ubc_cnt #(
  parameter int unsigned LIMIT = 4
) (
  input  wire logic i_mclk,
  input  wire logic i_nrst,
  input  wire logic i_run,
  output logic      o_done
);
  localparam int unsigned W   = $clog2(LIMIT + 1);
  localparam logic [W-1:0] LIM = W'(LIMIT);
  logic [W-1:0] cnt_r;

  // Saturating run-time counter, cleared when the condition drops
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_r <= '0;
    end else if (!i_run) begin
      cnt_r <= '0;
    end else if (cnt_r != LIM) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign o_done = (cnt_r == LIM);
endmodule : ubc_cnt

// [logic/ubc_ep.sv]
`timescale 1ns/10ps
module ubc_ep (
  input  wire logic               i_mclk,
  input  wire logic               i_nrst,
  input  wire logic               i_clr,
  input  wire logic               i_ep_rst,
  input  wire logic [1:0]         i_type,
  input  wire logic               i_wr,
  input  wire logic [7:0]         i_wdata,
  input  wire logic               i_hit,
  input  wire ubc_pkg::ubc_sie_type i_sie,
  output logic [7:0]              o_sta,
  output logic                    o_int
);
  import ubc_pkg::*;
  logic [7:0] sta_r;
  logic       is_ctrl;
  logic       is_iso;
  logic       ev_setup;
  logic [7:0] set_v;
  logic [7:0] w1c_v;

  assign is_ctrl  = (i_type == EPT_CTRL);
  assign is_iso   = (i_type == EPT_ISO);
  assign ev_setup = i_hit & i_sie.setup;

  // Hardware-set flags, one per event
  always_comb begin
    set_v            = '0;
    set_v[SB_TRANSMIT_COMPLETE_FLAG] = i_hit & i_sie.in_ack;
    set_v[SB_SETUP]  = ev_setup;
    set_v[SB_RXB0]   = i_hit & i_sie.out_ok & ~i_sie.out_bank1;
    set_v[SB_RXB1]   = i_hit & i_sie.out_ok & i_sie.out_bank1;
    set_v[SB_STALLD] = i_hit & i_sie.stall_sent & ~is_iso;
  end
  assign w1c_v = i_wr ? (i_wdata & STA_FLAGS) : 8'h00;

  // Sticky flags: a set in the clearing cycle wins
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      sta_r <= 8'h00;
    end else if (i_clr) begin
      sta_r <= 8'h00;
    end else begin
      for (int b = 0; b < 8; b++) begin
        if (STA_FLAGS[b]) begin
          if (b == SB_STALLD && ev_setup) begin
            sta_r[b] <= 1'b0;
          end else if (set_v[b]) begin
            sta_r[b] <= 1'b1;
          end else if (w1c_v[b]) begin
            sta_r[b] <= 1'b0;
          end
        end
      end
      // Stall request: firmware owned, dropped by SETUP on control
      if (ev_setup && is_ctrl) begin
        sta_r[SB_STALLQ] <= 1'b0;
      end else if (i_wr) begin
        sta_r[SB_STALLQ] <= i_wdata[SB_STALLQ] & ~is_iso;
      end
      // Transmit ready: set by firmware, dropped once the IN is taken
      if (i_hit && i_sie.in_ack) begin
        sta_r[SB_TRANSMIT_READY_FLAG] <= 1'b0;
      end else if (i_wr) begin
        sta_r[SB_TRANSMIT_READY_FLAG] <= i_wdata[SB_TRANSMIT_READY_FLAG];
      end
      // Data toggle tracking
      if (i_ep_rst) begin
        sta_r[SB_TOGGLE] <= 1'b0;
      end else if (ev_setup) begin
        sta_r[SB_TOGGLE] <= 1'b1;
      end else if (i_hit && i_sie.out_ok && !is_iso) begin
        sta_r[SB_TOGGLE] <= ~i_sie.data1;
      end
    end
  end

  assign o_sta = sta_r;
  assign o_int = |(sta_r & STA_FLAGS);
endmodule : ubc_ep

// [logic/ubc_top.sv]
// Chosen here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/10ps
module ubc_top #(
  parameter int unsigned SUSP_CYC  = ubc_pkg::SUSP_IDLE_CYC,
  parameter int unsigned RMIN_CYC  = ubc_pkg::RSM_MIN_CYC,
  parameter int unsigned RDRV_CYC  = ubc_pkg::RSM_DRIVE_CYC
) (
  input  wire logic                   i_mclk,
  input  wire logic                   i_nrst,
  input  wire logic                   i_hsel,
  input  wire logic [31:0]            i_haddr,
  input  wire logic [1:0]             i_htrans,
  input  wire logic                   i_hwrite,
  input  wire logic [2:0]             i_hsize,
  input  wire logic [31:0]            i_hwdata,
  input  wire logic                   i_hready,
  output logic                        o_hreadyout,
  output logic [31:0]                 o_hrdata,
  output logic                        o_hresp,
  input  wire ubc_pkg::ubc_sie_type   i_sie,
  output ubc_pkg::ubc_ep_ctl_type     o_ep,
  output logic                        o_usb_en,
  output logic                        o_addr_en,
  output logic                        o_pad_idle,
  output logic                        o_resume_k,
  output logic                        o_vref_out,
  output logic                        o_vref_oe,
  output logic                        o_usb_irq
);
  import ubc_pkg::*;

  localparam int unsigned EPW = $clog2(NEP);

  // Bus slave state
  logic             wr_pend_r;
  logic [7:0]       wr_addr_r;
  logic             hresp_r;
  logic [31:0]      hrdata_r;
  logic             hready_r;
  logic             addr_ok;
  logic             wr_ctrl;
  logic             wr_evt;
  logic             wr_en;
  logic             wr_sel;
  logic             wr_sta;
  logic             wr_cfg;
  logic             wr_rst;

  // Register file
  logic [7:0]       ctrl_r;
  logic [7:0]       evt_r;
  logic [15:0]      evt_en_r;
  logic [EPW-1:0]   ep_sel_r;
  logic [1:0]       ep_type_r [NEP];
  logic [10:0]      fnum_r;
  logic             crc_ok_r;
  logic             crc_err_r;

  // Event side
  logic             usb_clr;
  logic             clk_on;
  logic             idle_done;
  logic             idle_done_d_r;
  logic             se0_done;
  logic             se0_seen_r;
  logic             rst_det;
  logic             eor_ev;
  logic             susp_ev;
  logic             wup_ev;
  logic             suspended_r;
  logic             pad_idle_r;
  logic             susp_min_done;
  logic             drive_done;
  logic             drive_r;
  logic             irq_r;
  logic [7:0]       ep_sta   [NEP];
  logic [NEP-1:0]   ep_int;
  logic [NEP-1:0]   ep_rst_v;
  logic [31:0]      rd_mux;

  // Address phase: single word transfers, every answer OKAY
  assign addr_ok = i_hsel & i_htrans[1] & i_hready;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_ok & i_hwrite;
      if (addr_ok) begin
        wr_addr_r <= i_haddr[7:0];
      end
    end
  end

  // Data phase write strobes; unmapped offsets are ignored
  assign wr_ctrl = wr_pend_r & (wr_addr_r == OFS_CTRL);
  assign wr_evt  = wr_pend_r & (wr_addr_r == OFS_EVT);
  assign wr_en   = wr_pend_r & (wr_addr_r == OFS_EVT_EN);
  assign wr_sel  = wr_pend_r & (wr_addr_r == OFS_EP_SEL);
  assign wr_sta  = wr_pend_r & (wr_addr_r == OFS_EP_STA);
  assign wr_cfg  = wr_pend_r & (wr_addr_r == OFS_EP_CFG);
  assign wr_rst  = wr_pend_r & (wr_addr_r == OFS_EP_RST);

  // Read multiplexer, unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (i_haddr[7:0])
      OFS_CTRL:   rd_mux[7:0]     = ctrl_r;
      OFS_EVT:    rd_mux[7:0]     = evt_r;
      OFS_EVT_EN: rd_mux[15:0]    = evt_en_r;
      OFS_EP_SEL: rd_mux[EPW-1:0] = ep_sel_r;
      OFS_EP_STA: rd_mux[7:0]     = ep_sta[ep_sel_r];
      OFS_EP_CFG: rd_mux[1:0]     = ep_type_r[ep_sel_r];
      OFS_FNUM: begin
        rd_mux[10:0]       = fnum_r;
        rd_mux[FB_FRAME_CRC_GOOD]   = crc_ok_r;
        rd_mux[FB_FRAME_CRC_ERROR]  = crc_err_r;
      end
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data is captured in the address phase, zero wait states
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      hrdata_r <= 32'h0000_0000;
      hready_r <= 1'b1;
      hresp_r  <= 1'b0;
    end else begin
      hready_r <= 1'b1;
      hresp_r  <= 1'b0;
      if (addr_ok && !i_hwrite) begin
        hrdata_r <= rd_mux;
      end
    end
  end

  // USB registers return to reset on disable or at end of bus reset
  assign usb_clr = ~ctrl_r[CB_USBE] | eor_ev;
  assign clk_on  = ctrl_r[CB_USBE] & ~ctrl_r[CB_SUSPCK];

  // Global control register
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_r <= CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r             <= i_hwdata[7:0];
        ctrl_r[CB_UPSTREAM_RESUME_FLAG]   <= ctrl_r[CB_UPSTREAM_RESUME_FLAG];
      end
      if (eor_ev) begin
        ctrl_r             <= CTRL_RST;
        ctrl_r[CB_USBE]    <= 1'b1;
        ctrl_r[CB_SUSPCK]  <= ctrl_r[CB_SUSPCK];
      end else if (rst_det) begin
        ctrl_r[CB_CONFIGURED_BIT]   <= 1'b0;
        ctrl_r[CB_ADDRESS_ENABLE_BIT]  <= 1'b0;
      end
      // Upstream resume flag: raised by send-wakeup, dropped when done
      if (drive_done && drive_r) begin
        ctrl_r[CB_UPSTREAM_RESUME_FLAG]   <= 1'b0;
      end else if (ctrl_r[CB_SDWUP] && ctrl_r[CB_REMOTE_WAKEUP_ENABLE]
                   && !evt_r[EB_SUSP] && suspended_r) begin
        ctrl_r[CB_UPSTREAM_RESUME_FLAG]   <= 1'b1;
      end
    end
  end

  // Event enables, endpoint select, endpoint types
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      evt_en_r <= 16'h0000;
      ep_sel_r <= '0;
      for (int e = 0; e < NEP; e++) begin
        ep_type_r[e] <= EPT_CTRL;
      end
    end else if (usb_clr) begin
      evt_en_r <= 16'h0000;
      ep_sel_r <= '0;
      for (int e = 0; e < NEP; e++) begin
        ep_type_r[e] <= EPT_CTRL;
      end
    end else begin
      if (wr_en) begin
        evt_en_r <= i_hwdata[15:0];
      end
      if (wr_sel && (i_hwdata[EPW-1:0] < EPW'(NEP))) begin
        ep_sel_r <= i_hwdata[EPW-1:0];
      end
      if (wr_cfg) begin
        ep_type_r[ep_sel_r] <= i_hwdata[1:0];
      end
    end
  end

  // Suspend: idle time counted only with controller and clock on
  ubc_cnt #(.LIMIT(SUSP_CYC)) u_idle (
    .i_mclk (i_mclk),
    .i_nrst (i_nrst),
    .i_run  (clk_on & i_sie.bus_idle),
    .o_done (idle_done)
  );

  // Bus reset: SE0 held for the full-speed bit count
  ubc_cnt #(.LIMIT(BUS_RST_CYC)) u_se0 (
    .i_mclk (i_mclk),
    .i_nrst (i_nrst),
    .i_run  (ctrl_r[CB_USBE] & i_sie.se0),
    .o_done (se0_done)
  );

  // Time spent in suspend before a remote wake-up may go out
  ubc_cnt #(.LIMIT(RMIN_CYC)) u_smin (
    .i_mclk (i_mclk),
    .i_nrst (i_nrst),
    .i_run  (suspended_r),
    .o_done (susp_min_done)
  );

  // Length of the driven resume signalling
  ubc_cnt #(.LIMIT(RDRV_CYC)) u_drv (
    .i_mclk (i_mclk),
    .i_nrst (i_nrst),
    .i_run  (drive_r),
    .o_done (drive_done)
  );

  assign susp_ev = idle_done & ~idle_done_d_r;
  assign rst_det = se0_done & ~se0_seen_r;
  assign eor_ev  = se0_seen_r & ~i_sie.se0;
  assign wup_ev  = suspended_r & ~i_sie.bus_idle & ~drive_r;

  // Edge memories for the detectors
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      idle_done_d_r <= 1'b0;
      se0_seen_r    <= 1'b0;
    end else begin
      idle_done_d_r <= idle_done;
      if (eor_ev || !ctrl_r[CB_USBE]) begin
        se0_seen_r  <= 1'b0;
      end else if (se0_done) begin
        se0_seen_r  <= 1'b1;
      end
    end
  end

  // Global event flags: write one to clear, a new event wins
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      evt_r <= 8'h00;
    end else if (!ctrl_r[CB_USBE]) begin
      evt_r <= 8'h00;
    end else begin
      for (int b = 0; b < 8; b++) begin
        if (wr_evt && i_hwdata[b] && EVT_MASK[b]) begin
          evt_r[b] <= 1'b0;
        end
      end
      if (i_sie.sof) begin
        evt_r[EB_SOF]  <= 1'b1;
      end
      if (susp_ev) begin
        evt_r[EB_SUSP] <= 1'b1;
      end
      if (wup_ev) begin
        evt_r[EB_WUP]  <= 1'b1;
      end
      if (eor_ev) begin
        evt_r[EB_EOR]  <= 1'b1;
      end
    end
  end

  // Frame number and CRC result of the last start-of-frame
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      fnum_r    <= 11'h000;
      crc_ok_r  <= 1'b0;
      crc_err_r <= 1'b0;
    end else if (usb_clr) begin
      fnum_r    <= 11'h000;
      crc_ok_r  <= 1'b0;
      crc_err_r <= 1'b0;
    end else if (i_sie.sof) begin
      fnum_r    <= i_sie.frame_num;
      crc_ok_r  <= i_sie.sof_crc_ok;
      crc_err_r <= ~i_sie.sof_crc_ok;
    end
  end

  // Suspend state, pad idle mode and resume drive
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      suspended_r <= 1'b0;
      pad_idle_r  <= 1'b0;
      drive_r     <= 1'b0;
    end else if (usb_clr) begin
      suspended_r <= 1'b0;
      pad_idle_r  <= 1'b0;
      drive_r     <= 1'b0;
    end else begin
      if (susp_ev) begin
        suspended_r <= 1'b1;
      end else if (wup_ev || (drive_r && drive_done)) begin
        suspended_r <= 1'b0;
      end
      if (wup_ev || drive_r) begin
        pad_idle_r  <= 1'b0;
      end else if (wr_evt && i_hwdata[EB_SUSP] && evt_r[EB_SUSP]) begin
        pad_idle_r  <= 1'b1;
      end
      if (drive_r && drive_done) begin
        drive_r     <= 1'b0;
      end else if (ctrl_r[CB_UPSTREAM_RESUME_FLAG] && clk_on && susp_min_done) begin
        drive_r     <= 1'b1;
      end
    end
  end

  // Endpoint reset pulses from the reset register
  assign ep_rst_v = wr_rst ? i_hwdata[NEP-1:0] : '0;

  // One status block per endpoint
  for (genvar e = 0; e < NEP; e++) begin : g_ep
    ubc_ep u_ep (
      .i_mclk   (i_mclk),
      .i_nrst   (i_nrst),
      .i_clr    (usb_clr | ep_rst_v[e]),
      .i_ep_rst (ep_rst_v[e]),
      .i_type   (ep_type_r[e]),
      .i_wr     (wr_sta & (ep_sel_r == EPW'(e))),
      .i_wdata  (i_hwdata[7:0]),
      .i_hit    (i_sie.ep == 3'(e)),
      .i_sie    (i_sie),
      .o_sta    (ep_sta[e]),
      .o_int    (ep_int[e])
    );
    assign o_ep.stall[e]  = ep_sta[e][SB_STALLQ];
    assign o_ep.tx_rdy[e] = ep_sta[e][SB_TRANSMIT_READY_FLAG];
    assign o_ep.toggle[e] = ep_sta[e][SB_TOGGLE];
  end

  // Single interrupt request from all enabled sources
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= (|(evt_r & evt_en_r[7:0]))
             | (|(ep_int & evt_en_r[EN_EP_LSB +: NEP]));
    end
  end

  assign o_hreadyout = hready_r;
  assign o_hrdata    = hrdata_r;
  assign o_hresp     = hresp_r;
  assign o_usb_en    = ctrl_r[CB_USBE];
  assign o_addr_en   = ctrl_r[CB_ADDRESS_ENABLE_BIT];
  assign o_pad_idle  = pad_idle_r;
  assign o_resume_k  = drive_r;
  assign o_vref_out  = 1'b1;
  assign o_vref_oe   = ~ctrl_r[CB_DETACH];
  assign o_usb_irq   = irq_r;
endmodule : ubc_top
